// File: rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-stage synchroniser for slow levels
// ----------------------------------------------------------------------

module level_sync
    import mode_seq_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,               // System clock.
    input wire logic rstn,              // Async reset, active low.
    input wire logic [WIDTH-1:0] d,     // Asynchronous level inputs.
    output logic [WIDTH-1:0] q          // Synchronised levels.
);

    logic [WIDTH-1:0] meta;  // First stage, read only by the second.
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // Next values are just a shift along the chain.
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    // Both stages reset to a constant low level.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {WIDTH{SYNC_RST}};
            q <= {WIDTH{SYNC_RST}};
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule : level_sync
`default_nettype wire

// File: rtl/mode_seq_pkg.sv
package mode_seq_pkg;

    // ------------------------------------------------------------------
    // Operating modes and timing
    // ------------------------------------------------------------------

    // The four device modes.
    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_SLEEP,
        MODE_OPERATING,
        MODE_FAULT
    } mode_e;

    // Number of fault sources handled by the sequencer.
    localparam int NUM_FAULTS = 4;

    // Default delays in microseconds, converted to cycles at 50 MHz.
    localparam int CLK_MHZ = 50;
    localparam int STARTUP_US = 100;
    localparam int WAKE_US = 100;
    localparam int SLEEP_US = 20;
    localparam int SHDN_US = 10;
    localparam int RCVR_US = 50;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
    localparam int SHDN_CYC = SHDN_US * CLK_MHZ;
    localparam int RCVR_CYC = RCVR_US * CLK_MHZ;

    // Width of the shared delay counter.
    localparam int CNT_W = 16;

    // Reset value of the synchroniser stages.
    localparam logic SYNC_RST = 1'b0;

    // Block enables driven toward the analog supplies and the driver.
    typedef struct packed {
        logic main_regulator;   // Main regulator enable.
        logic aux_regulator;    // Auxiliary regulator enable.
        logic aux_clamp;        // Clamp feeding the aux supply rail.
        logic buck_boost;       // Buck-boost chain: converter, pump, drive.
        logic driver;           // Gate driver outputs follow controls.
    } enables_s;

    // Per-fault-source active-low disable masks for the buck-boost, driver and aux regulator.
    typedef struct packed {
        logic buck_boost_n;     // Low disables the buck-boost chain.
        logic driver_n;         // Low disables the gate driver.
        logic aux_regulator_n;  // Low disables the auxiliary regulator.
    } fault_mask_s;

endpackage : mode_seq_pkg

// File: rtl/operating_mode_sequencer.sv
// Operation
// (RULE1) Exactly four modes, one active at once.
// (RULE2) Supply below falling threshold means shutdown.
// (RULE3) Shutdown: only main regulator, aux clamp on.
// (RULE4) Sleep: driver disabled, control inputs ignored.
// (RULE5) Sleep: buck-boost off, main and aux on.
// (RULE6) Operating: buck-boost on, main off, driver follows.
// (RULE7) Operating only while no fault present.
// (RULE8) Fault mode reports on fault_out_n.
// (RULE9) Fault mode block enables depend on source.
// (RULE10) Shutdown to sleep after startup delay.
// (RULE11) Enable held high: operating after wake delay.
// (RULE12) Enable held low: sleep after entry delay.
// (RULE13) Supply loss: shutdown, delayed from sleep/fault.
// (RULE14) Any fault in operating enters fault mode.
// (RULE15) Fault cleared: operating after recovery delay.
// (RULE16) Further faults accepted, disables ANDed together.
// (RULE17) Enable low in fault: sleep after recovery.
// (RULE18) Enable synchronised; delays are build parameters.
// (RULE19) Reset held low supply; starts in shutdown.
`timescale 1ns/1ps
`default_nettype none

module operating_mode_sequencer
    import mode_seq_pkg::*;
#(
    parameter int NF = NUM_FAULTS,
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int SLEEP_CYCLES = SLEEP_CYC,
    parameter int SHDN_CYCLES = SHDN_CYC,
    parameter int RCVR_CYCLES = RCVR_CYC
) (
    input wire logic clk,                    // 50 MHz logic clock.
    input wire logic rstn,                   // Async reset, active low.
    input wire logic supply_ok,              // Supply above POR, async pin.
    input wire logic enable_in,              // Host enable level, async pin.
    input wire logic [NF-1:0] fault_in,      // Fault levels, same clock.
    input wire fault_mask_s [NF-1:0] fault_mask, // Per-source disables.
    input wire logic high_side_control_in,   // High-side control input.
    input wire logic low_side_control_in,    // Low-side control input.
    output mode_e mode,                      // Current mode.
    output enables_s enables,                // Block enables.
    output logic high_side_drive,            // Gated high-side command.
    output logic low_side_drive,             // Gated low-side command.
    output logic fault_out_n,                // Fault report, active low.
    output logic [NF-1:0] fault_status       // Latched fault sources.
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------

    logic [1:0] sync_q;  // Synchronised supply_ok and enable.
    logic supply_s;      // Supply good after synchronisation.
    logic enable_s;      // Host enable after synchronisation.

    // Both pins are asynchronous to clk, so they pass two flops first.
    level_sync #(.WIDTH(2)) u_sync ( // RULE18
        .clk(clk),
        .rstn(rstn),
        .d({supply_ok, enable_in}),
        .q(sync_q)
    );

    assign supply_s = sync_q[1];
    assign enable_s = sync_q[0];

    // ------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------

    // Converts a cycle count parameter into the counter width.
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? CNT_W'(0) : CNT_W'(n - 1);
    endfunction : cyc

    mode_e next_mode;              // Next mode value.
    logic [CNT_W-1:0] cnt;         // Delay counter for pending moves.
    logic [CNT_W-1:0] next_cnt;
    logic any_fault;               // Any fault source is active.

    assign any_fault = |fault_in;

    // One process picks the next mode; a pending move counts its delay
    // and the count clears only when no move is pending, so a glitch on the
    // host enable does not half-complete a transition outside fault mode.
    always_comb begin
        next_mode = mode;
        next_cnt = '0;
        case (mode)
            MODE_SHUTDOWN: begin
                if (supply_s) begin
                    if (cnt == cyc(STARTUP_CYCLES)) begin
                        next_mode = MODE_SLEEP; // RULE10
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end
            MODE_SLEEP: begin
                if (!supply_s) begin
                    if (cnt == cyc(SHDN_CYCLES)) begin
                        next_mode = MODE_SHUTDOWN; // RULE13
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end else if (enable_s) begin
                    if (cnt == cyc(WAKE_CYCLES)) begin
                        next_mode = MODE_OPERATING; // RULE11
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end
            MODE_OPERATING: begin
                // Supply loss from operating is immediate.
                if (!supply_s) begin
                    next_mode = MODE_SHUTDOWN; // RULE13
                end else if (any_fault) begin
                    next_mode = MODE_FAULT; // RULE14 RULE7
                end else if (!enable_s) begin
                    if (cnt == cyc(SLEEP_CYCLES)) begin
                        next_mode = MODE_SLEEP; // RULE12
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end
            MODE_FAULT: begin
                if (!supply_s) begin
                    if (cnt == cyc(SHDN_CYCLES)) begin
                        next_mode = MODE_SHUTDOWN; // RULE13
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end else if (!enable_s) begin
                    // Sleep request wins over recovery, even mid-fault.
                    if (cnt == cyc(RCVR_CYCLES)) begin
                        next_mode = MODE_SLEEP; // RULE17
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end else if (!any_fault) begin
                    if (cnt == cyc(RCVR_CYCLES)) begin
                        next_mode = MODE_OPERATING; // RULE15
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end
            default: begin
                next_mode = MODE_SHUTDOWN;
            end
        endcase
    end

    // Reset always lands in shutdown; the supply monitor holds rstn low
    // while the supply is under the threshold.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_SHUTDOWN; // RULE19 RULE2 RULE1
            cnt <= '0;
        end else begin
            mode <= next_mode;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Fault latch and combined disables
    // ------------------------------------------------------------------

    logic [NF-1:0] next_fault_status;  // Next latched sources.
    fault_mask_s combined;             // AND of active source masks.

    // Sources stay latched through fault mode, new ones add in; the
    // latch clears on the very edge that leaves fault mode, so the
    // status never outlives the mode that it describes.
    always_comb begin
        next_fault_status = fault_status;
        if (next_mode == MODE_FAULT) begin
            next_fault_status = fault_status | fault_in; // RULE16
        end else begin
            next_fault_status = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_status <= '0;
        end else begin
            fault_status <= next_fault_status;
        end
    end

    // Active-low disables from every active source are ANDed.
    always_comb begin
        combined = '1;
        for (int i = 0; i < NF; i++) begin
            if (fault_status[i] || fault_in[i]) begin
                combined = combined & fault_mask[i]; // RULE16
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    enables_s next_enables;   // Next block enables.
    logic next_fault_out_n;   // Next fault report.
    logic next_hs;            // Next gated high-side command.
    logic next_ls;            // Next gated low-side command.

    // Enables follow the mode being entered, so they change with it.
    always_comb begin
        next_enables = '0;
        next_fault_out_n = 1'b1;
        case (next_mode)
            MODE_SHUTDOWN: begin
                next_enables.main_regulator = 1'b1; // RULE3
                next_enables.aux_clamp = 1'b1;
            end
            MODE_SLEEP: begin
                next_enables.main_regulator = 1'b1; // RULE5
                next_enables.aux_regulator = 1'b1;
            end
            MODE_OPERATING: begin
                next_enables.aux_regulator = 1'b1; // RULE6
                next_enables.buck_boost = 1'b1;
                next_enables.driver = 1'b1;
            end
            MODE_FAULT: begin
                // Fault source decides what survives.
                next_enables.aux_regulator = combined.aux_regulator_n; // RULE9
                next_enables.aux_clamp = ~combined.aux_regulator_n;
                next_enables.buck_boost = combined.buck_boost_n;
                next_enables.driver = combined.driver_n;
                next_fault_out_n = 1'b0; // RULE8
            end
            default: begin
                next_enables = '0;
            end
        endcase
        // Driver commands pass only while the driver is enabled.
        next_hs = next_enables.driver & high_side_control_in; // RULE4
        next_ls = next_enables.driver & low_side_control_in;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enables <= '{main_regulator: 1'b1, aux_regulator: 1'b0,
                         aux_clamp: 1'b1, buck_boost: 1'b0, driver: 1'b0};
            fault_out_n <= 1'b1;
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b0;
        end else begin
            enables <= next_enables;
            fault_out_n <= next_fault_out_n;
            high_side_drive <= next_hs;
            low_side_drive <= next_ls;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    chk_fault_entry: assert property (@(posedge clk) // RULE14
        disable iff (!rstn)
        (mode == MODE_OPERATING && supply_s && any_fault)
        |=> (mode == MODE_FAULT))
        else $error("fault in operating did not enter fault mode");

    chk_fault_report: assert property (@(posedge clk) // RULE8
        disable iff (!rstn)
        (mode == MODE_FAULT) |-> !fault_out_n)
        else $error("fault mode without fault report");

    chk_sleep_driver: assert property (@(posedge clk) // RULE4
        disable iff (!rstn)
        (mode == MODE_SLEEP) |-> !high_side_drive && !low_side_drive)
        else $error("driver active in sleep");

    chk_sleep_supply: assert property (@(posedge clk) // RULE5
        disable iff (!rstn)
        (mode == MODE_SLEEP) |-> enables.main_regulator
        && enables.aux_regulator && !enables.buck_boost)
        else $error("sleep enables wrong");

    chk_oper_supply: assert property (@(posedge clk) // RULE6
        disable iff (!rstn)
        (mode == MODE_OPERATING) |-> !enables.main_regulator
        && enables.buck_boost && enables.driver)
        else $error("operating enables wrong");

    chk_shdn_supply: assert property (@(posedge clk) // RULE3
        disable iff (!rstn)
        (mode == MODE_SHUTDOWN) |-> enables.main_regulator
        && enables.aux_clamp && !enables.aux_regulator && !enables.driver)
        else $error("shutdown enables wrong");

    chk_oper_drop: assert property (@(posedge clk) // RULE13
        disable iff (!rstn)
        (mode == MODE_OPERATING && !supply_s) |=> (mode == MODE_SHUTDOWN))
        else $error("operating did not drop to shutdown");

    chk_no_skip: assert property (@(posedge clk) // RULE10
        disable iff (!rstn)
        ($past(mode) == MODE_SHUTDOWN)
        |-> (mode == MODE_SHUTDOWN || mode == MODE_SLEEP))
        else $error("shutdown left for a wrong mode");

    chk_wake_delay: assert property (@(posedge clk) // RULE11
        disable iff (!rstn)
        (mode == MODE_SLEEP && $past(mode) != MODE_SLEEP) |=>
        (mode != MODE_OPERATING))
        else $error("wake without delay");

    // The entry checks below assume every delay is two cycles or more.
    chk_sleep_delay: assert property (@(posedge clk) // RULE12
        disable iff (!rstn)
        (mode == MODE_OPERATING && $past(mode) != MODE_OPERATING)
        |=> (mode != MODE_SLEEP))
        else $error("sleep entered without delay");

    chk_fault_hold: assert property (@(posedge clk) // RULE15 RULE17
        disable iff (!rstn)
        (mode == MODE_FAULT && $past(mode) != MODE_FAULT)
        |=> (mode == MODE_FAULT))
        else $error("fault mode left without delay");

    chk_sleep_hold: assert property (@(posedge clk) // RULE12
        disable iff (!rstn)
        (mode == MODE_SLEEP && supply_s && !enable_s)
        |=> (mode == MODE_SLEEP))
        else $error("sleep left while enable low");

    chk_status_clear: assert property (@(posedge clk) // RULE16
        disable iff (!rstn)
        (mode != MODE_FAULT) |-> (fault_status == '0))
        else $error("fault status kept outside fault mode");

    cov_wake: cover property (@(posedge clk) disable iff (!rstn)
        $past(mode) == MODE_SLEEP && mode == MODE_OPERATING);
    cov_fault: cover property (@(posedge clk) disable iff (!rstn)
        $past(mode) == MODE_OPERATING && mode == MODE_FAULT);
    cov_recover: cover property (@(posedge clk) disable iff (!rstn)
        $past(mode) == MODE_FAULT && mode == MODE_OPERATING);
    cov_sleep: cover property (@(posedge clk) disable iff (!rstn)
        $past(mode) == MODE_OPERATING && mode == MODE_SLEEP);
    cov_fault_sleep: cover property (@(posedge clk) disable iff (!rstn)
        $past(mode) == MODE_FAULT && mode == MODE_SLEEP);

endmodule : operating_mode_sequencer
`default_nettype wire

// File: verif/host_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Host controller: drives the enable level, watches fault reports
// ---------------------------------------------------------------

module host_mcu_model (
    input wire logic clk,         // System clock.
    input wire logic want_run,    // Run request from the bench.
    input wire logic slow,        // Delay each enable change by 3 cycles.
    input wire logic fault_out_n, // Fault report, active low.
    output logic enable_in,       // Enable level toward the device.
    output int fault_reports      // Cycles seen with a fault reported.
);
    logic [2:0] pipe; // Delay line for the slow host.

    initial begin
        pipe = '0;
        enable_in = 1'b0;
        fault_reports = 0;
    end

    // The level is held until the bench asks otherwise, so a request
    // stays stable for the whole delay the device needs.
    always @(posedge clk) begin
        pipe <= {pipe[1:0], want_run};
        enable_in <= slow ? pipe[2] : want_run;
        if (fault_out_n === 1'b0) begin
            fault_reports <= fault_reports + 1;
        end
    end
endmodule : host_mcu_model

`default_nettype wire

// File: verif/operating_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module operating_mode_sequencer_tb_top;
    import mode_seq_pkg::*;

    // -----------------------------------------------------------
    // Short delays keep the run brief.
    // -----------------------------------------------------------
    localparam int ST = 6, WK = 5, SL = 4, SD = 4, RC = 7;

    // Expected mode change with its allowed cycle window.
    typedef struct packed {
        mode_e m;
        logic [3:0] act;
        int t_lo;
        int t_hi;
    } note_s;

    logic clk, rstn, supply_ok, want_run, slow, hi, lo, hi_d, lo_d;
    logic enable_in, hsd, lsd, fon;
    logic [3:0] fin, fst, f0;
    fault_mask_s [3:0] fmask;
    mode_e mode, mp;
    mode_e last = MODE_SHUTDOWN; // Mode seen at the previous watch.
    enables_s en;
    int n_fail, checks_done, cyc, reports, r0, k;
    note_s q[$];
    note_s nt;

    operating_mode_sequencer #(.NF(4), .STARTUP_CYCLES(ST),
        .WAKE_CYCLES(WK), .SLEEP_CYCLES(SL), .SHDN_CYCLES(SD),
        .RCVR_CYCLES(RC)) uut (
        .clk(clk), .rstn(rstn), .supply_ok(supply_ok),
        .enable_in(enable_in), .fault_in(fin), .fault_mask(fmask),
        .high_side_control_in(hi), .low_side_control_in(lo),
        .mode(mode), .enables(en), .high_side_drive(hsd),
        .low_side_drive(lsd), .fault_out_n(fon), .fault_status(fst));

    host_mcu_model host (.clk(clk), .want_run(want_run), .slow(slow),
        .fault_out_n(fon), .enable_in(enable_in),
        .fault_reports(reports));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle count for timing windows; also cuts a hang short.
    initial cyc = 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            n_fail++;
            end_of_test();
        end
    end

    // Control inputs toggle at random all the time.
    always @(posedge clk) begin
        #1 {hi, lo} = 2'($urandom);
    end

    task automatic cmp(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // Enables the device must show in a mode; fault disables are ANDed.
    function automatic enables_s exp_en(mode_e m, logic [3:0] act);
        enables_s e;
        e = '0;
        case (m)
            MODE_SHUTDOWN: begin
                e.main_regulator = 1'b1;
                e.aux_clamp = 1'b1;
            end
            MODE_SLEEP: begin
                e.main_regulator = 1'b1;
                e.aux_regulator = 1'b1;
            end
            default: begin
                e.aux_regulator = 1'b1;
                e.buck_boost = 1'b1;
                e.driver = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (m == MODE_FAULT && act[i]) begin
                        e.aux_regulator &= fmask[i].aux_regulator_n;
                        e.buck_boost &= fmask[i].buck_boost_n;
                        e.driver &= fmask[i].driver_n;
                    end
                end
                e.aux_clamp = (m == MODE_FAULT) && !e.aux_regulator;
            end
        endcase
        return e;
    endfunction : exp_en

    // Compares a mode change with the oldest expectation.
    task automatic check_note(input note_s n);
        cmp(mode, n.m, "mode");
        cmp(en, exp_en(n.m, n.act), "enables");
        cmp(fon, n.m != MODE_FAULT, "fault pin");
        cmp(fst, n.act, "fault status");
        cmp(cyc >= n.t_lo && cyc <= n.t_hi, 1, "timing");
    endtask : check_note

    // Watcher: each mode change consumes one note.
    always @(negedge clk) begin
        if (rstn && mode !== last) begin
            if (q.size() == 0) begin
                cmp(mode, last, "unexpected mode change");
            end else begin
                nt = q.pop_front();
                check_note(nt);
            end
        end
        last = mode;
        // Drives follow controls one cycle late while running and stay low in sleep and shutdown.
        if (rstn && mode === mp) begin
            if (mode == MODE_OPERATING) begin
                cmp({hsd, lsd}, {hi_d, lo_d}, "drive follow");
            end else if (mode != MODE_FAULT) begin
                cmp({hsd, lsd}, 2'b00, "drive idle");
            end
        end
    end
    always @(posedge clk) begin
        hi_d <= hi;
        lo_d <= lo;
        mp <= mode;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic expect_mode(input mode_e m, input logic [3:0] a,
                               input int lo_c, input int hi_c);
        q.push_back({m, a, cyc + lo_c, cyc + hi_c});
    endtask : expect_mode

    // Bounded wait until every note has been consumed.
    task automatic wait_done();
        for (int i = 0; i < 60 && q.size() != 0; i++) @(posedge clk);
        if (q.size() != 0) begin
            n_fail++;
            $display("BAD %0t mode change missing", $time);
            q.delete();
        end
        step();
    endtask : wait_done

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // -----------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------
    initial begin
        rstn = 1'b0;
        supply_ok = 1'b0;
        want_run = 1'b0;
        slow = 1'b1;
        fin = '0;
        fmask = '1;
        n_fail = 0;
        checks_done = 0;
        r0 = $urandom(32'heb15);
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        cmp(mode, MODE_SHUTDOWN, "reset mode");
        cmp(en, exp_en(MODE_SHUTDOWN, 0), "reset enables");
        supply_ok = 1'b1;
        expect_mode(MODE_SLEEP, 0, ST, ST + 4);
        wait_done();
        // Faults are ignored while asleep.
        fin = 4'h1;
        repeat (5) step();
        cmp(mode, MODE_SLEEP, "fault in sleep");
        cmp({fon, fst}, 5'h10, "fault in sleep ignored");
        fin = '0;
        want_run = 1'b1;
        expect_mode(MODE_OPERATING, 0, WK, WK + 8);
        wait_done();
        // Each source in turn, then a second one joins.
        for (k = 0; k < 4; k++) begin
            fmask = 12'($urandom);
            r0 = reports;
            f0 = 4'(1 << k);
            fin = f0;
            expect_mode(MODE_FAULT, f0, 1, 1);
            wait_done();
            cmp(reports != r0, 1, "host saw fault");
            fin = f0 | 4'(1 << ((k + 1) % 4));
            repeat (3) step();
            cmp(en, exp_en(MODE_FAULT, fin), "anded masks");
            cmp(fst, fin, "both latched");
            fin = '0;
            expect_mode(MODE_OPERATING, 0, RC, RC + 2);
            wait_done();
        end
        // Enable drops while in fault mode.
        slow = 1'b0;
        fin = 4'h4;
        expect_mode(MODE_FAULT, 4'h4, 1, 1);
        wait_done();
        want_run = 1'b0;
        expect_mode(MODE_SLEEP, 0, RC, RC + 5);
        wait_done();
        fin = '0;
        want_run = 1'b1;
        expect_mode(MODE_OPERATING, 0, WK, WK + 5);
        wait_done();
        want_run = 1'b0;
        expect_mode(MODE_SLEEP, 0, SL, SL + 5);
        wait_done();
        supply_ok = 1'b0;
        expect_mode(MODE_SHUTDOWN, 0, SD, SD + 4);
        wait_done();
        // Supply loss straight from operating.
        want_run = 1'b1;
        supply_ok = 1'b1;
        expect_mode(MODE_SLEEP, 0, ST, ST + 4);
        wait_done();
        expect_mode(MODE_OPERATING, 0, WK - 4, WK + 2);
        wait_done();
        supply_ok = 1'b0;
        expect_mode(MODE_SHUTDOWN, 0, 1, 4);
        wait_done();
        // Supply loss from fault mode, then a mid-run reset.
        supply_ok = 1'b1;
        expect_mode(MODE_SLEEP, 0, ST, ST + 4);
        wait_done();
        expect_mode(MODE_OPERATING, 0, WK - 4, WK + 2);
        wait_done();
        fin = 4'h8;
        expect_mode(MODE_FAULT, 4'h8, 1, 1);
        wait_done();
        supply_ok = 1'b0;
        expect_mode(MODE_SHUTDOWN, 0, SD, SD + 4);
        wait_done();
        fin = '0;
        supply_ok = 1'b1;
        expect_mode(MODE_SLEEP, 0, ST, ST + 4);
        wait_done();
        rstn = 1'b0;
        step();
        cmp(mode, MODE_SHUTDOWN, "mid-run reset");
        cmp(en, exp_en(MODE_SHUTDOWN, 0), "mid-run enables");
        rstn = 1'b1;
        expect_mode(MODE_SLEEP, 0, ST, ST + 4);
        wait_done();
        end_of_test();
    end
endmodule : operating_mode_sequencer_tb_top

`default_nettype wire
